// [inc/cfg_port_pkg.sv]
// constants shared by the configuration data intake port and its buffer
// assumes a 100 MHz reference clock and a host-driven configuration clock in slave modes
`default_nettype none

package cfg_port_pkg;

    // reference clock rate and derived timing
    localparam int REF_CLK_MHZ    = 100;
    localparam int CLEAR_TIME_NS  = 1000;  // memory clear interval after reset or restart
    localparam int CLEAR_CYCLES   = (CLEAR_TIME_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int CLK_START_NS   = 500;   // least delay from release to master clock start
    localparam int CLK_START_CYC  = (CLK_START_NS * REF_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] HALF_PERIOD_BASE = 8'h04;  // master half period at rate option 0

    // configuration mode encodings on the mode select inputs
    localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
    localparam logic [2:0] MODE_SERMEM_MASTER = 3'h1;
    localparam logic [2:0] MODE_PARMEM_UP     = 3'h2;
    localparam logic [2:0] MODE_PARMEM_DOWN   = 3'h3;
    localparam logic [2:0] MODE_SLAVE_PARALLEL = 3'h6;
    localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;

    // reset value and buffer sizes
    localparam logic [2:0] MODE_RESET_VALUE   = MODE_SLAVE_SERIAL;
    localparam int BYTE_WIDTH   = 8;
    localparam int BUFFER_DEPTH = 2;

    // sequencing of power-on clear and reset release
    typedef enum logic [1:0] {
        ST_CLEAR   = 2'b01,
        ST_RELEASE = 2'b10
    } init_state_e;

endpackage
`default_nettype wire

// [hw/cfg_pair_buffer.sv]
// small buffer between the link handshake and the user-side byte stream
// assumes one clock; flush empties it and wins over a push in the same cycle
`timescale 1ns/1ps
`default_nettype none

module cfg_pair_buffer #(
    parameter int WIDTH = cfg_port_pkg::BYTE_WIDTH,
    parameter int DEPTH = cfg_port_pkg::BUFFER_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    wire              push;
    wire              pop;

    // honest flags; full refuses the producer so it must wait
    assign in_ready  = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    ////////////////
    // storage; the array holds no control state so it needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule // cfg_pair_buffer
`default_nettype wire

// [hw/slave_config_data_port.sv]
// configuration data intake port: serial and slave parallel link side,
// power-on clear sequencing, master clock generation and byte delivery
// assumes config_clock is the pad level (looped back in master modes)
`timescale 1ns/1ps
`default_nettype none

module slave_config_data_port (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       restart_request_n,
    input  wire logic [2:0] mode_select_inputs,
    input  wire logic [1:0] master_clock_rate_option,
    input  wire logic       config_clock,
    output logic            config_clock_out,
    output logic            config_clock_oe,
    input  wire logic       serial_data_in,
    output logic            daisy_out,
    input  wire logic       select_n,
    input  wire logic       direction_select,
    input  wire logic [7:0] parallel_byte_bus_in,
    output logic      [7:0] parallel_byte_bus_out,
    output logic            parallel_byte_bus_oe,
    output logic            busy,
    output logic            memory_clear,
    output logic            reset_release,
    output logic      [2:0] active_mode,
    output logic      [7:0] config_byte,
    output logic            config_valid,
    input  wire logic       config_ready,
    output logic            config_abort,
    output logic            serial_overrun
);

    ////////////////
    // reference domain: pin synchronisers (three stages, second and third agree)
    logic [2:0] restart_sync;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic [2:0] mode_s3;
    logic       restart_level;
    logic [2:0] mode_level;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            restart_sync <= 3'h7;
            mode_s1      <= cfg_port_pkg::MODE_RESET_VALUE;
            mode_s2      <= cfg_port_pkg::MODE_RESET_VALUE;
            mode_s3      <= cfg_port_pkg::MODE_RESET_VALUE;
        end else begin
            restart_sync <= {restart_sync[1:0], restart_request_n};
            mode_s1      <= mode_select_inputs;
            mode_s2      <= mode_s1;
            mode_s3      <= mode_s2;
        end
    end

    // filtered levels; a change counts once the last two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_mode_filter
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    mode_level[gi] <= cfg_port_pkg::MODE_RESET_VALUE[gi];
                end else if (mode_s2[gi] == mode_s3[gi]) begin
                    mode_level[gi] <= mode_s3[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            restart_level <= 1'b1;
        end else if (restart_sync[1] == restart_sync[2]) begin
            restart_level <= restart_sync[2];
        end
    end

    ////////////////
    // power-on and restart sequencing: clear, then raise the release
    cfg_port_pkg::init_state_e state;
    logic [15:0] clear_cnt;
    wire         clear_done = (clear_cnt == 16'(cfg_port_pkg::CLEAR_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state       <= cfg_port_pkg::ST_CLEAR;
            clear_cnt   <= '0;
            active_mode <= cfg_port_pkg::MODE_RESET_VALUE;
        end else if (!restart_level) begin
            state     <= cfg_port_pkg::ST_CLEAR;
            clear_cnt <= '0;
        end else begin
            case (state)
                cfg_port_pkg::ST_CLEAR: begin
                    clear_cnt <= clear_cnt + 16'h0001;
                    if (clear_done) begin
                        state       <= cfg_port_pkg::ST_RELEASE;
                        active_mode <= mode_level;
                    end
                end
                cfg_port_pkg::ST_RELEASE: begin
                    state <= cfg_port_pkg::ST_RELEASE;
                end
                default: begin
                    state     <= cfg_port_pkg::ST_CLEAR;
                    clear_cnt <= '0;
                end
            endcase
        end
    end

    assign memory_clear  = (state == cfg_port_pkg::ST_CLEAR);
    assign reset_release = (state == cfg_port_pkg::ST_RELEASE);

    ////////////////
    // master clock: start delay after release, then a divider from ref_clk
    wire is_master = (active_mode == cfg_port_pkg::MODE_MASTER_SERIAL)
                   | (active_mode == cfg_port_pkg::MODE_SERMEM_MASTER)
                   | (active_mode == cfg_port_pkg::MODE_PARMEM_UP)
                   | (active_mode == cfg_port_pkg::MODE_PARMEM_DOWN);
    wire [7:0] half_period = cfg_port_pkg::HALF_PERIOD_BASE << master_clock_rate_option;
    logic [7:0] start_cnt;
    logic [7:0] half_cnt;
    logic       clk_run;
    wire        start_due = (start_cnt == 8'(cfg_port_pkg::CLK_START_CYC - 1));

    // exact division keeps the rate well inside the allowed half either way
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_cnt        <= '0;
            half_cnt         <= '0;
            clk_run          <= 1'b0;
            config_clock_out <= 1'b0;
        end else if (!(reset_release && is_master)) begin
            start_cnt        <= '0;
            half_cnt         <= '0;
            clk_run          <= 1'b0;
            config_clock_out <= 1'b0;
        end else if (!clk_run) begin
            start_cnt <= start_cnt + 8'h01;
            clk_run   <= start_due;
        end else if (half_cnt >= half_period - 8'h01) begin
            half_cnt         <= '0;
            config_clock_out <= ~config_clock_out;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end

    assign config_clock_oe = reset_release & is_master;

    ////////////////
    // link domain: release level and mode cross by two flip-flops
    logic       rel_l1;
    logic       rel_l2;
    logic [2:0] mode_l1;
    logic [2:0] mode_l2;
    logic       ack_l1;
    logic       ack_l2;
    logic       ack_core;

    always_ff @(posedge config_clock or negedge rstn) begin
        if (!rstn) begin
            rel_l1  <= 1'b0;
            rel_l2  <= 1'b0;
            mode_l1 <= cfg_port_pkg::MODE_RESET_VALUE;
            mode_l2 <= cfg_port_pkg::MODE_RESET_VALUE;
            ack_l1  <= 1'b0;
            ack_l2  <= 1'b0;
        end else begin
            rel_l1  <= reset_release;
            rel_l2  <= rel_l1;
            mode_l1 <= active_mode;  // static while released
            mode_l2 <= mode_l1;
            ack_l1  <= ack_core;
            ack_l2  <= ack_l1;
        end
    end

    // link-side decode
    logic       req_tgl;
    logic       abort_tgl;
    logic       prev_sel_n;
    logic       prev_dir;
    logic [6:0] shreg;
    logic [2:0] bit_cnt;
    logic [7:0] hold;
    logic       din_q;
    wire l_serial = rel_l2 & ((mode_l2 == cfg_port_pkg::MODE_SLAVE_SERIAL)
                            | (mode_l2 == cfg_port_pkg::MODE_MASTER_SERIAL));
    wire l_par    = rel_l2 & (mode_l2 == cfg_port_pkg::MODE_SLAVE_PARALLEL);
    wire pending  = req_tgl ^ ack_l2;
    wire abort_hit = l_par & ~select_n & ~prev_sel_n
                   & (direction_select != prev_dir);
    wire par_take  = l_par & ~select_n & ~direction_select
                   & ~busy & ~abort_hit;
    wire ser_done  = l_serial & (bit_cnt == 3'h7);
    wire launch    = (par_take | ser_done) & ~pending;
    wire [7:0] new_byte = l_par ? parallel_byte_bus_in : {shreg, serial_data_in};
    wire next_req  = req_tgl ^ launch;

    // capture on every rising edge of the configuration clock
    always_ff @(posedge config_clock or negedge rstn) begin
        if (!rstn) begin
            req_tgl    <= 1'b0;
            abort_tgl  <= 1'b0;
            prev_sel_n <= 1'b1;
            prev_dir   <= 1'b0;
            shreg      <= '0;
            bit_cnt    <= '0;
            hold       <= '0;
            din_q      <= 1'b0;
            busy       <= 1'b0;
        end else begin
            prev_sel_n <= select_n;
            prev_dir   <= direction_select;
            req_tgl    <= next_req;
            abort_tgl  <= abort_tgl ^ abort_hit;
            busy       <= l_par & (next_req ^ ack_l2);
            if (launch) begin
                hold <= new_byte;
            end
            if (l_serial) begin
                din_q   <= serial_data_in;
                shreg   <= {shreg[5:0], serial_data_in};
                bit_cnt <= bit_cnt + 3'h1;
            end else begin
                bit_cnt <= '0;
            end
        end
    end

    // overrun when a serial byte completes before the last one left
    always_ff @(posedge config_clock or negedge rstn) begin
        if (!rstn) begin
            serial_overrun <= 1'b0;
        end else if (!rel_l2) begin
            serial_overrun <= 1'b0;
        end else if (ser_done && pending) begin
            serial_overrun <= 1'b1;
        end
    end

    // daisy output moves on the falling edge so the next device sees it settled
    always_ff @(negedge config_clock or negedge rstn) begin
        if (!rstn) begin
            daisy_out <= 1'b0;
        end else if (l_serial) begin
            daisy_out <= din_q;
        end
    end

    // read-back status byte; drivers follow the direction pin directly
    always_ff @(posedge config_clock or negedge rstn) begin
        if (!rstn) begin
            parallel_byte_bus_out <= '0;
        end else begin
            parallel_byte_bus_out <= {busy, serial_overrun, pending, rel_l2, 1'b0, mode_l2};
        end
    end

    assign parallel_byte_bus_oe = l_par & direction_select;

    ////////////////
    // reference domain: request and abort toggles cross by two flip-flops
    logic [2:0] req_sync;
    logic [2:0] abort_sync;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req_sync     <= '0;
            abort_sync   <= '0;
            config_abort <= 1'b0;
        end else begin
            req_sync     <= {req_sync[1:0], req_tgl};
            abort_sync   <= {abort_sync[1:0], abort_tgl};
            config_abort <= abort_sync[1] ^ abort_sync[2];
        end
    end

    // the byte is held on the link side until the acknowledge returns
    wire buf_in_ready;
    wire req_seen = req_sync[1] ^ ack_core;
    wire push     = req_seen & buf_in_ready;

    // a full buffer withholds the acknowledge, so busy stays high at the host in slave parallel mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_core <= 1'b0;
        end else if (push) begin
            ack_core <= ~ack_core;
        end
    end

    cfg_pair_buffer #(
        .WIDTH (cfg_port_pkg::BYTE_WIDTH),
        .DEPTH (cfg_port_pkg::BUFFER_DEPTH)
    ) u_buffer (
        .clk       (ref_clk),
        .rstn      (rstn),
        .flush     (memory_clear),
        .in_data   (hold),
        .in_valid  (req_seen),
        .in_ready  (buf_in_ready),
        .out_data  (config_byte),
        .out_valid (config_valid),
        .out_ready (config_ready)
    );

endmodule // slave_config_data_port
`default_nettype wire

// [dv/slave_config_data_port_sva.sv]
// concurrent checks on the configuration intake port, core clock view
// assumes the link clock is slower than half the core clock
`timescale 1ns/1ps
`default_nettype none

module cfg_port_sva (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic [2:0] mode_select_inputs,
    input wire logic [1:0] master_clock_rate_option,
    input wire logic       config_clock,
    input wire logic       config_clock_out,
    input wire logic       config_clock_oe,
    input wire logic       daisy_out,
    input wire logic       select_n,
    input wire logic       direction_select,
    input wire logic       parallel_byte_bus_oe,
    input wire logic       busy,
    input wire logic       memory_clear,
    input wire logic       reset_release,
    input wire logic [2:0] active_mode,
    input wire logic       config_abort,
    input wire logic       config_valid,
    input wire logic       config_ready,
    input wire logic       serial_overrun
);
    localparam int START_LO = cfg_port_pkg::CLK_START_CYC - 2;
    localparam int CLEAR_LO = cfg_port_pkg::CLEAR_CYCLES - 2;
    int   clear_run;
    int   rel_run;
    int   half_run;
    logic seen_tog;
    logic last_out;
    wire logic master_mode = !active_mode[2];
    wire logic par_mode    = active_mode == cfg_port_pkg::MODE_SLAVE_PARALLEL;
    wire logic tog         = config_clock_out != last_out;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    ////////////////
    // run lengths, a cycle or two of slack
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clear_run <= 0;
            rel_run   <= 0;
            half_run  <= 0;
            seen_tog  <= 1'b0;
            last_out  <= 1'b0;
        end else begin
            clear_run <= memory_clear ? clear_run + 1 : 0;
            rel_run   <= reset_release ? rel_run + 1 : 0;
            half_run  <= tog ? 0 : half_run + 1;
            seen_tog  <= config_clock_oe && (seen_tog || tog);
            last_out  <= config_clock_out;
        end
    end

    ////////////////
    // link-side timing and handshake
    chk_bus_drive_dir: assert property (parallel_byte_bus_oe == (par_mode && direction_select))
        else $error("bus drive off");
    chk_busy_on_rise: assert property ($changed(busy) && reset_release |-> $rose(config_clock))
        else $error("busy off rise");
    chk_daisy_on_fall: assert property ($changed(daisy_out) && reset_release |-> $fell(config_clock))
        else $error("daisy off fall");
    chk_take_needs_select: assert property ($rose(busy) |-> !select_n && !direction_select)
        else $error("take without select");
    chk_abort_single: assert property ($rose(config_abort) |-> par_mode ##1 !config_abort)
        else $error("bad abort pulse");

    ////////////////
    // clearing, mode latch and master clock
    chk_clock_drive_mode: assert property (config_clock_oe == (reset_release && master_mode))
        else $error("clock drive mode");
    chk_clear_before_release: assert property ($rose(reset_release) |-> clear_run >= CLEAR_LO)
        else $error("early release");
    chk_mode_latched: assert property ($rose(reset_release) |-> active_mode == $past(mode_select_inputs, 5))
        else $error("mode not latched");
    chk_master_start: assert property (tog && !seen_tog && config_clock_oe |-> rel_run inside {[START_LO:400]})
        else $error("start window");
    chk_master_half: assert property (tog && seen_tog |->
        half_run inside {[(2 << master_clock_rate_option) - 1 : (6 << master_clock_rate_option) - 1]})
        else $error("half period off");

    cover property ($rose(busy));
    cover property ($rose(config_abort));
    cover property ($rose(serial_overrun));
    cover property (config_valid && config_ready);
endmodule // cfg_port_sva
`default_nettype wire

// [dv/cfg_host_model.sv]
// behavioural configuration host: link clock only inside frames,
// serial bits, parallel bytes held under busy, and the abort sequence
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
    output logic       host_clk,
    output logic       serial_bit,
    output logic       host_select_n,
    output logic       host_direction,
    output logic [7:0] host_bus,
    input  wire logic  busy,
    input  wire logic  daisy_out
);
    logic busy_pre;
    logic daisy_seen;

    // idle levels; the clock stands still between frames
    initial begin
        host_clk       = 1'b0;
        serial_bit     = 1'b0;
        host_select_n  = 1'b1;
        host_direction = 1'b0;
        host_bus       = 8'h00;
    end

    ////////////////
    // one 48 ns link period, below every clock ceiling; data moves after the fall
    task automatic pulse();
        busy_pre = busy;
        #24 host_clk = 1'b1;
        #23 host_clk = 1'b0;
        #1 daisy_seen = daisy_out;
    endtask

    task automatic idle(input int n);
        repeat (n) pulse();
    endtask

    // msb first; the released line shows the inverse of its last bit
    task automatic ser_byte(input logic [7:0] b, output logic [7:0] echo);
        for (int i = 7; i >= 0; i--) begin
            serial_bit = b[i];
            pulse();
            echo[i] = daisy_seen;
        end
        serial_bit = ~b[0];
    endtask

    // byte stays put until a rising edge sees busy low
    task automatic par_byte(input logic [7:0] b, input int limit, output logic taken);
        taken          = 1'b0;
        host_select_n  = 1'b0;
        host_direction = 1'b0;
        host_bus       = b;
        for (int n = 0; n < limit && !taken; n++) begin
            pulse();
            taken = !busy_pre;
        end
        host_select_n = 1'b1;
        host_bus      = ~b;
    endtask

    // bus inverted before direction rises, then direction flips under select
    task automatic read_turn();
        host_bus       = ~host_bus;
        host_select_n  = 1'b0;
        host_direction = 1'b1;
    endtask

    task automatic abort_tail();
        pulse();
        host_direction = 1'b0;
        pulse();
        host_select_n = 1'b1;
    endtask
endmodule // cfg_host_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the configuration intake port
// assumes the dv/ host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic       ref_clk;
    logic       rstn;
    logic       restart_request_n;
    logic [2:0] mode_select_inputs;
    logic [1:0] master_clock_rate_option;
    logic       config_ready;
    wire logic  host_clk, serial_bit, host_select_n, host_direction, busy, daisy_out;
    wire logic  clk_out, clk_oe, bus_oe, clear, released, valid, abort, overrun;
    wire logic [7:0] host_bus, bus_out, cfg_byte;
    wire logic [2:0] mode;
    wire logic       link_clk = clk_oe ? clk_out : host_clk;  // master loops its clock back
    wire logic [7:0] bus_in   = bus_oe ? bus_out : host_bus;
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         aborts = 0;
    logic [7:0] got[$];

    slave_config_data_port DUT (.ref_clk, .rstn, .restart_request_n, .mode_select_inputs,
        .master_clock_rate_option, .config_clock(link_clk), .config_clock_out(clk_out),
        .config_clock_oe(clk_oe), .serial_data_in(serial_bit), .daisy_out,
        .select_n(host_select_n), .direction_select(host_direction),
        .parallel_byte_bus_in(bus_in), .parallel_byte_bus_out(bus_out),
        .parallel_byte_bus_oe(bus_oe), .busy, .memory_clear(clear), .reset_release(released),
        .active_mode(mode), .config_byte(cfg_byte), .config_valid(valid), .config_ready,
        .config_abort(abort), .serial_overrun(overrun));
    cfg_host_model host (.host_clk, .serial_bit, .host_select_n, .host_direction, .host_bus,
        .busy, .daisy_out);

    ////////////////
    // clock, byte and abort collection, hang limit
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (valid === 1'b1 && config_ready === 1'b1) got.push_back(cfg_byte);
        if (abort === 1'b1) aborts++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    ////////////////
    // shared helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] pop();
        return got.size() > 0 ? got.pop_front() : 8'hxx;
    endfunction
    task automatic wait_release(input logic [2:0] m);
        for (int n = 0; n < 400 && released !== 1'b1; n++) @(negedge ref_clk);
        chk("active_mode", {5'h00, mode}, {5'h00, m});
        chk("memory_clear", {7'h00, clear}, 8'h00);
        got.delete();
    endtask
    task automatic restart(input logic [2:0] m);
        @(negedge ref_clk);
        mode_select_inputs = m;
        restart_request_n  = 1'b0;
        fork
            host.idle(4);  // link must see the release drop
            repeat (40) @(negedge ref_clk);  // wider than the shortest restart pulse
        join
        restart_request_n = 1'b1;
        wait_release(m);
    endtask
    task automatic half_period(output int cnt);
        logic last;
        for (int k = 0; k < 3; k++) begin
            last = clk_out;
            cnt  = 0;
            while (clk_out === last && cnt < 600) begin
                @(negedge ref_clk);
                cnt++;
            end
        end
    endtask

    ////////////////
    // scenarios
    task automatic t_serial();
        logic [7:0] pat[3] = '{8'ha5, 8'h3c, 8'h81};
        logic [7:0] echo;
        restart(cfg_port_pkg::MODE_SLAVE_SERIAL);
        host.idle(2);
        foreach (pat[i]) begin
            host.ser_byte(pat[i], echo);
            chk("daisy echo", echo, pat[i]);
        end
        repeat (10) @(negedge ref_clk);
        foreach (pat[i]) chk("serial byte", pop(), pat[i]);
        config_ready = 1'b0;
        for (int i = 0; i < 4; i++) host.ser_byte(8'h10 + 8'(i), echo);
        repeat (10) @(negedge ref_clk);
        chk("overrun", {7'h00, overrun}, 8'h01);
        config_ready = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("stalled byte 0", pop(), 8'h10);
        chk("stalled byte 1", pop(), 8'h11);
        $display("test serial done");
    endtask

    task automatic t_parallel();
        logic [7:0] pb[3] = '{8'h11, 8'h22, 8'h33};
        logic       t;
        restart(cfg_port_pkg::MODE_SLAVE_PARALLEL);
        chk("overrun cleared", {7'h00, overrun}, 8'h00);
        chk("clock drive", {7'h00, clk_oe}, 8'h00);
        host.idle(3);
        @(negedge ref_clk);
        config_ready = 1'b0;
        foreach (pb[i]) begin
            host.par_byte(pb[i], 20, t);
            chk("byte accepted", {7'h00, t}, 8'h01);
        end
        host.par_byte(8'h44, 20, t);
        chk("full refused", {7'h00, t}, 8'h00);
        host.idle(4);
        @(negedge ref_clk);
        config_ready = 1'b1;
        host.par_byte(8'h44, 40, t);
        chk("held byte accepted", {7'h00, t}, 8'h01);
        host.idle(6);
        repeat (10) @(negedge ref_clk);
        foreach (pb[i]) chk("parallel byte", pop(), pb[i]);
        chk("parallel byte", pop(), 8'h44);
        chk("select high took", 8'(got.size()), 8'h00);
        host.read_turn();
        #1 chk("read drive", {7'h00, bus_oe}, 8'h01);
        host.abort_tail();
        repeat (10) @(negedge ref_clk);
        chk("abort pulses", 8'(aborts), 8'h01);
        chk("abort took", 8'(got.size()), 8'h00);
        chk("write release", {7'h00, bus_oe}, 8'h00);
        $display("test parallel done");
    endtask

    task automatic t_master();
        int hp;
        restart(cfg_port_pkg::MODE_MASTER_SERIAL);
        chk("clock drive", {7'h00, clk_oe}, 8'h01);
        for (int o = 0; o < 2; o++) begin
            @(negedge ref_clk);
            master_clock_rate_option = 2'(o);
            half_period(hp);
            chk("half period", 8'(hp), cfg_port_pkg::HALF_PERIOD_BASE << o);
        end
        $display("test master done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset, then the scenarios
    initial begin
        rstn                     = 1'b0;
        restart_request_n        = 1'b1;
        mode_select_inputs       = cfg_port_pkg::MODE_SLAVE_SERIAL;
        master_clock_rate_option = 2'h0;
        config_ready             = 1'b1;
        fork
            host.idle(2);
            repeat (20) @(negedge ref_clk);
        join
        chk("reset outputs", {clear, released, busy, valid, abort, mode}, 8'h87);
        rstn = 1'b1;
        wait_release(cfg_port_pkg::MODE_SLAVE_SERIAL);
        t_serial();
        t_parallel();
        t_master();
        tally_and_finish();
    end
endmodule // tb_top

bind slave_config_data_port cfg_port_sva chk_i (.ref_clk, .rstn, .mode_select_inputs,
    .master_clock_rate_option, .config_clock, .config_clock_out, .config_clock_oe, .daisy_out,
    .select_n, .direction_select, .parallel_byte_bus_oe, .busy, .memory_clear, .reset_release,
    .active_mode, .config_abort, .config_valid, .config_ready, .serial_overrun);
`default_nettype wire
